// file: inc/seg_loader_pkg.sv
/*
 * Constants, register indices and state codes of the segment loader.
 * Assumes a byte-wide configuration register space outside the block
 * and registers reached as 32-bit words at four times their index.
 */
// Behaviour
// - writing one to the commit bit copies buffered registers to active.
// - that copy happens at the first rising serial clock edge after the write.
// - the commit bit clears itself once the copy has fired.
// - a list byte with bit 7 clear starts a data-transfer entry.
// - the low seven bits of such a byte hold the byte count minus one.
// - the two bytes after the command give the start address, high byte first.
// - start address and count pick the config bytes saved or restored.
// - a list byte with bit 7 set is an instruction: commit or end.
// - the commit instruction acts like software writing one to commit.
// - the end instruction stops the walk and ends the save or restore.
// - a read-only busy flag is one while a save or restore runs, zero after.
package seg_loader_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] REG_COMMIT_IDX = 12'h232;
    localparam logic [11:0] REG_CTRL_IDX = 12'h240;
    localparam logic [11:0] REG_LIST_IDX = 12'h300;
    localparam logic [11:0] REG_STATUS_IDX = 12'hb00;
    localparam int ADDR_W = 14;

    // field positions
    localparam int COMMIT_BIT = 0;
    localparam int CTRL_SAVE_BIT = 0;
    localparam int CTRL_LOAD_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int CMD_OP_BIT = 7;

    // instruction codes and list reset contents
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_END = 8'hff;
    localparam logic [7:0] LIST_RESET = 8'hff;
    localparam int LIST_DEPTH_DEF = 128;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_CMD = 7'h02,
        S_ADDR_HI = 7'h04,
        S_ADDR_LO = 7'h08,
        S_MOVE = 7'h10,
        S_COMMIT = 7'h20,
        S_FINISH = 7'h40
    } state_t;

endpackage

// file: hw/pair_buffer.sv
/*
 * Small FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module pair_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("pair_buffer depth must be a power of two, two or more");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// file: hw/commit_unit.sv
/*
 * Holds a commit request and fires it on the next serial clock rise.
 * Assumes sclk is a level synchronous to aclk.
 */
`timescale 1ns/100ps
module commit_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic req,
    output logic pending,
    output logic fire
);
    logic sclk_q_r, sclk_q_nxt;
    logic pend_r, pend_nxt;
    logic fire_r, fire_nxt;
    logic rise;

    assign rise = sclk && !sclk_q_r;
    assign pending = pend_r;
    assign fire = fire_r;

    always_comb begin
        sclk_q_nxt = sclk;
        // a new request in the firing cycle stays pending
        pend_nxt = req || (pend_r && !rise);
        fire_nxt = pend_r && rise;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_q_r <= 1'b0;
            pend_r <= 1'b0;
            fire_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk_q_nxt;
            pend_r <= pend_nxt;
            fire_r <= fire_nxt;
        end
    end
endmodule

// file: hw/eeprom_segment_loader.sv
/*
 * Segment list walker with AXI4-Lite registers, commit logic and the
 * byte path between config space and nonvolatile memory.
 * Assumes cfg_rdata answers cfg_addr in the same cycle and the memory
 * side streams bytes in list order.
 */
`timescale 1ns/100ps
module eeprom_segment_loader
    import seg_loader_pkg::*;
#(
    parameter int LIST_DEPTH = LIST_DEPTH_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk,
    output logic commit_apply,
    output logic [15:0] cfg_addr,
    input wire logic [7:0] cfg_rdata,
    output logic cfg_we,
    output logic [7:0] cfg_wdata,
    output logic nvm_save,
    output logic nvm_wvalid,
    input wire logic nvm_wready,
    output logic [7:0] nvm_wdata,
    input wire logic nvm_rvalid,
    output logic nvm_rready,
    input wire logic [7:0] nvm_rdata,
    output logic busy
);
    localparam int LW = $clog2(LIST_DEPTH);

    if (LIST_DEPTH < 4 || LIST_DEPTH > 1024) begin : g_chk
        $error("list depth must lie between 4 and 1024");
    end

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [11:0] aw_idx_r, aw_idx_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic wlane_r, wlane_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic do_wr, wr_en, sw_commit, start_save, start_load, list_wr;
    logic [11:0] wr_off, rd_idx, rd_off;
    logic [7:0] list_mem [LIST_DEPTH];
    logic commit_pending, loader_commit;
    state_t state_r;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    assign do_wr = aw_have_r && w_have_r && !bvalid_r;
    assign wr_en = do_wr && wlane_r;
    assign wr_off = aw_idx_r - REG_LIST_IDX;
    assign list_wr = wr_en && (wr_off < 12'(LIST_DEPTH));
    assign sw_commit = wr_en && (aw_idx_r == REG_COMMIT_IDX)
        && wbyte_r[COMMIT_BIT];
    assign start_save = wr_en && (aw_idx_r == REG_CTRL_IDX)
        && wbyte_r[CTRL_SAVE_BIT] && (state_r == S_IDLE);
    assign start_load = wr_en && (aw_idx_r == REG_CTRL_IDX)
        && wbyte_r[CTRL_LOAD_BIT] && (state_r == S_IDLE);
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];
    assign rd_off = rd_idx - REG_LIST_IDX;

    always_comb begin
        aw_have_nxt = aw_have_r;
        aw_idx_nxt = aw_idx_r;
        w_have_nxt = w_have_r;
        wbyte_nxt = wbyte_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_idx_nxt = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            wbyte_nxt = s_axi_wdata[7:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if (aw_idx_r != REG_COMMIT_IDX && aw_idx_r != REG_CTRL_IDX
                && aw_idx_r != REG_STATUS_IDX
                && !(wr_off < 12'(LIST_DEPTH))) begin
                bresp_nxt = RESP_SLVERR;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt = '0;
            rresp_nxt = RESP_OKAY;
            if (rd_idx == REG_COMMIT_IDX) begin
                rdata_nxt[COMMIT_BIT] = commit_pending;
            end else if (rd_idx == REG_STATUS_IDX) begin
                rdata_nxt[STATUS_BUSY_BIT] = busy;
            end else if (rd_idx == REG_CTRL_IDX) begin
                rdata_nxt[CTRL_SAVE_BIT] = busy && nvm_save;
                rdata_nxt[CTRL_LOAD_BIT] = busy && !nvm_save;
            end else if (rd_off < 12'(LIST_DEPTH)) begin
                rdata_nxt[7:0] = list_mem[rd_off[LW-1:0]];
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_idx_r <= '0;
            w_have_r <= 1'b0;
            wbyte_r <= '0;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            aw_have_r <= aw_have_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_have_r <= w_have_nxt;
            wbyte_r <= wbyte_nxt;
            wlane_r <= wlane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // list memory, cleared to end instructions
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < LIST_DEPTH; i++) begin
                list_mem[i] <= LIST_RESET;
            end
        end else if (list_wr) begin
            list_mem[wr_off[LW-1:0]] <= wbyte_r;
        end
    end

    // ------------------------------------------------------------
    // commit
    // ------------------------------------------------------------
    commit_unit u_commit (
        .aclk(aclk),
        .aresetn(aresetn),
        .sclk(sclk),
        .req(sw_commit || loader_commit),
        .pending(commit_pending),
        .fire(commit_apply)
    );

    // ------------------------------------------------------------
    // list walker
    // ------------------------------------------------------------
    state_t state_nxt;
    logic [LW:0] ptr_r, ptr_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0] left_in_r, left_in_nxt, left_out_r, left_out_nxt;
    logic save_r, save_nxt, we_r, we_nxt;
    logic [7:0] wdat_r, wdat_nxt, cmd;
    logic bin_valid, bin_ready, bout_valid, bout_ready;
    logic [7:0] bin_data, bout_data;
    logic moving;

    assign cmd = list_mem[ptr_r[LW-1:0]];
    assign moving = (state_r == S_MOVE);
    assign busy = (state_r != S_IDLE);
    assign nvm_save = save_r;
    assign cfg_addr = addr_r;
    assign cfg_we = we_r;
    assign cfg_wdata = wdat_r;
    assign loader_commit = (state_r == S_CMD) && cmd[CMD_OP_BIT]
        && (cmd == OP_COMMIT) && (ptr_r != (LW+1)'(LIST_DEPTH));

    // byte path: save reads config into memory, restore the reverse
    assign bin_valid = moving && (left_in_r != '0)
        && (save_r || nvm_rvalid);
    assign bin_data = save_r ? cfg_rdata : nvm_rdata;
    assign nvm_rready = moving && !save_r && (left_in_r != '0)
        && bin_ready;
    assign nvm_wvalid = save_r && bout_valid;
    assign nvm_wdata = bout_data;
    assign bout_ready = save_r ? nvm_wready : (moving && !we_r);

    pair_buffer #(.WIDTH(8), .DEPTH(2)) u_buf (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(bin_valid),
        .in_ready(bin_ready),
        .in_data(bin_data),
        .out_valid(bout_valid),
        .out_ready(bout_ready),
        .out_data(bout_data)
    );

    always_comb begin
        state_nxt = state_r;
        ptr_nxt = ptr_r;
        addr_nxt = addr_r;
        left_in_nxt = left_in_r;
        left_out_nxt = left_out_r;
        save_nxt = save_r;
        we_nxt = 1'b0;
        wdat_nxt = wdat_r;
        case (state_r)
            S_IDLE: begin
                if (start_save || start_load) begin
                    save_nxt = start_save;
                    ptr_nxt = '0;
                    state_nxt = S_CMD;
                end
            end
            S_CMD: begin
                if (ptr_r == (LW+1)'(LIST_DEPTH)) begin
                    state_nxt = S_FINISH;
                end else if (!cmd[CMD_OP_BIT]) begin
                    left_in_nxt = {1'b0, cmd[6:0]} + 8'h01;
                    left_out_nxt = {1'b0, cmd[6:0]} + 8'h01;
                    ptr_nxt = ptr_r + 1'b1;
                    state_nxt = S_ADDR_HI;
                end else if (cmd == OP_COMMIT) begin
                    ptr_nxt = ptr_r + 1'b1;
                    state_nxt = S_COMMIT;
                end else begin
                    // end code, and any unknown code, stops the walk
                    state_nxt = S_FINISH;
                end
            end
            S_ADDR_HI: begin
                addr_nxt = {cmd, addr_r[7:0]};
                ptr_nxt = ptr_r + 1'b1;
                state_nxt = (ptr_r == (LW+1)'(LIST_DEPTH)) ? S_FINISH
                    : S_ADDR_LO;
            end
            S_ADDR_LO: begin
                addr_nxt = {addr_r[15:8], cmd};
                ptr_nxt = ptr_r + 1'b1;
                state_nxt = (ptr_r == (LW+1)'(LIST_DEPTH)) ? S_FINISH
                    : S_MOVE;
            end
            S_MOVE: begin
                if (save_r) begin
                    if (bin_valid && bin_ready) begin
                        left_in_nxt = left_in_r - 8'h01;
                        addr_nxt = addr_r + 16'h0001;
                        if (left_in_r == 8'h01) begin
                            state_nxt = S_CMD;
                        end
                    end
                end else begin
                    if (bin_valid && bin_ready) begin
                        left_in_nxt = left_in_r - 8'h01;
                    end
                    if (we_r) begin
                        left_out_nxt = left_out_r - 8'h01;
                        addr_nxt = addr_r + 16'h0001;
                        if (left_out_r == 8'h01) begin
                            state_nxt = S_CMD;
                        end
                    end else if (bout_valid) begin
                        we_nxt = 1'b1;
                        wdat_nxt = bout_data;
                    end
                end
            end
            S_COMMIT: begin
                // wait for the copy to fire before the next entry
                if (!commit_pending) begin
                    state_nxt = S_CMD;
                end
            end
            S_FINISH: begin
                if (!bout_valid && !we_r) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
            ptr_r <= '0;
            addr_r <= '0;
            left_in_r <= '0;
            left_out_r <= '0;
            save_r <= 1'b0;
            we_r <= 1'b0;
            wdat_r <= '0;
        end else begin
            state_r <= state_nxt;
            ptr_r <= ptr_nxt;
            addr_r <= addr_nxt;
            left_in_r <= left_in_nxt;
            left_out_r <= left_out_nxt;
            save_r <= save_nxt;
            we_r <= we_nxt;
            wdat_r <= wdat_nxt;
        end
    end
endmodule

// file: testbench/loader_chk_sva.sv
/*
 * Port checker of the segment loader, bound into each loader instance.
 * Assumes it sees only top ports, one clock and active-low reset.
 */
`timescale 1ns/100ps
module loader_chk #(
    parameter int LIST_DEPTH = 128
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic sclk,
    input wire logic commit_apply,
    input wire logic cfg_we,
    input wire logic nvm_save,
    input wire logic nvm_wvalid,
    input wire logic nvm_wready,
    input wire logic [7:0] nvm_wdata,
    input wire logic nvm_rready,
    input wire logic busy
);
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_commit_pulse: assert property (commit_apply |=> !commit_apply)
        else $error("commit pulse longer than one cycle");
    a_commit_on_rise: assert property (commit_apply
        |-> $past(sclk) && !$past(sclk, 2))
        else $error("commit fired without a serial clock rise");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before ready");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    a_we_spacing: assert property (cfg_we |=> !cfg_we)
        else $error("config writes back to back");
    a_save_hold: assert property (nvm_wvalid && !nvm_wready
        |=> nvm_wvalid && $stable(nvm_wdata))
        else $error("save byte changed while stalled");
    a_restore_only: assert property (nvm_rready
        |-> busy && !nvm_save)
        else $error("restore stream taken outside a restore");
    a_idle_quiet: assert property (!busy
        |-> !nvm_wvalid && !nvm_rready)
        else $error("byte traffic while not busy");
endmodule
bind eeprom_segment_loader loader_chk #(.LIST_DEPTH(LIST_DEPTH)) chk (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .sclk, .commit_apply, .cfg_we, .nvm_save, .nvm_wvalid, .nvm_wready,
    .nvm_wdata, .nvm_rready, .busy);

// file: testbench/nvm_partner.sv
/*
 * Config register space and nonvolatile byte store facing the loader.
 * Assumes the bench loads restore bytes and reads saved bytes directly.
 */
`timescale 1ns/100ps
module nvm_partner (
    input wire logic aclk,
    input wire logic slow,
    input wire logic [15:0] cfg_addr,
    output logic [7:0] cfg_rdata,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_wdata,
    input wire logic nvm_wvalid,
    output logic nvm_wready,
    input wire logic [7:0] nvm_wdata,
    output logic nvm_rvalid,
    input wire logic nvm_rready,
    output logic [7:0] nvm_rdata
);
    // ----------------
    // storage
    // ----------------
    logic [7:0] cfg_mem [0:65535];
    logic [7:0] smem [0:63];
    logic [7:0] rmem [0:63];
    logic [7:0] last = 8'h00;
    int scnt = 0;
    int rptr = 0;
    int rcnt = 0;
    logic rhold = 1'b0;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            cfg_mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
        end
    end
    assign cfg_rdata = cfg_mem[cfg_addr];
    assign nvm_wready = !slow;
    // a raised valid stays up until its byte is taken
    assign nvm_rvalid = (rptr < rcnt) && (!slow || rhold);
    // idle data line shows the inverse of the last byte
    assign nvm_rdata = nvm_rvalid ? rmem[rptr[5:0]] : ~last;
    always @(posedge aclk) begin
        rhold <= nvm_rvalid && !nvm_rready;
        if (cfg_we) begin
            cfg_mem[cfg_addr] <= cfg_wdata;
        end
        if (nvm_wvalid && nvm_wready) begin
            smem[scnt[5:0]] <= nvm_wdata;
            scnt <= scnt + 1;
        end
        if (nvm_rvalid && nvm_rready) begin
            last <= rmem[rptr[5:0]];
            rptr <= rptr + 1;
        end
    end
endmodule

// file: testbench/test_eeprom_segment_loader.sv
/*
 * Self-checking bench of the segment loader: registers, commit, walks.
 * Assumes nvm_partner.sv and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
module test_eeprom_segment_loader;
    import seg_loader_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic sclk = 0, slow = 0, sclk_run = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, commit_apply, cfg_we, nvm_save, nvm_wvalid;
    wire nvm_wready, nvm_rvalid, nvm_rready, busy;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] cfg_addr;
    wire [7:0] cfg_rdata, cfg_wdata, nvm_wdata, nvm_rdata;
    int failures = 0, n_compared = 0, n_commit = 0, sdiv = 0, c1, n0;
    logic [31:0] rdv;
    logic [1:0] rs;
    logic [15:0] a1, a2;
    logic [7:0] lst [$];

    eeprom_segment_loader DUT (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk,
        .commit_apply, .cfg_addr, .cfg_rdata, .cfg_we, .cfg_wdata,
        .nvm_save, .nvm_wvalid, .nvm_wready, .nvm_wdata, .nvm_rvalid,
        .nvm_rready, .nvm_rdata, .busy);
    nvm_partner nvm (.aclk, .slow, .cfg_addr, .cfg_rdata, .cfg_we,
        .cfg_wdata, .nvm_wvalid, .nvm_wready, .nvm_wdata, .nvm_rvalid,
        .nvm_rready, .nvm_rdata);

    always #2 aclk = ~aclk;
    // random stalls of the far side, serial clock, commit pulse count
    always @(posedge aclk) begin
        slow <= 1'(($urandom & 3) == 0);
        if (sclk_run) begin
            sdiv <= sdiv + 1;
            if (sdiv % 4 == 3) sclk <= ~sclk;
        end
        if (commit_apply === 1'h1) n_commit <= n_commit + 1;
    end

    // ----------------
    // tasks
    // ----------------
    function automatic logic [13:0] ba(input logic [11:0] idx);
        return {idx, 2'h0};
    endfunction
    function automatic logic [7:0] cfg_init(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task reg_wr(input logic [13:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1'($urandom);
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'h1) begin
                aw_done = 1;
                s_axi_awvalid <= 0;
            end
            if (!w_done && s_axi_wready === 1'h1) begin
                w_done = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        if (s_axi_bready !== 1'h1) begin
            s_axi_bready <= 1;
            @(posedge aclk);
        end
        rs = s_axi_bresp;
    endtask
    task reg_rd(input logic [13:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1'($urandom);
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        if (s_axi_rready !== 1'h1) begin
            s_axi_rready <= 1;
            @(posedge aclk);
        end
        rdv = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task walk(input int bit_pos, input bit chk_busy);
        int i;
        foreach (lst[k]) reg_wr(ba(REG_LIST_IDX + 12'(k)), 32'(lst[k]));
        reg_wr(ba(REG_CTRL_IDX), 32'h1 << bit_pos);
        reg_rd(ba(REG_STATUS_IDX));
        if (chk_busy) check(rdv, 32'h1);
        if (chk_busy) check(32'(nvm_save), 32'(bit_pos == 0));
        i = 0;
        while (rdv[0] !== 1'h0 && i < 400) begin
            reg_rd(ba(REG_STATUS_IDX));
            i++;
        end
        check(rdv, 32'h0);
        check(32'(busy), 32'h0);
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge aclk);
        failures++;
        finish_test();
    end

    // ----------------
    // tests
    // ----------------
    initial begin
        void'($urandom(2361));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        reg_rd(ba(REG_LIST_IDX));
        check(rdv, 32'h0000_00ff);
        reg_rd(ba(REG_COMMIT_IDX));
        check(rdv, 32'h0);
        reg_wr(ba(REG_STATUS_IDX), 32'h1);
        check(32'(rs), 32'(RESP_OKAY));
        reg_rd(ba(REG_STATUS_IDX));
        check(rdv, 32'h0);
        reg_rd(14'h0004);
        check(32'(rs), 32'(RESP_SLVERR));
        $display("test registers done");
        reg_wr(ba(REG_COMMIT_IDX), 32'h1);
        repeat (8) @(posedge aclk);
        check(32'(n_commit), 32'h0);
        reg_rd(ba(REG_COMMIT_IDX));
        check(rdv, 32'h1);
        sclk_run <= 1;
        for (int i = 0; i < 30 && n_commit == 0; i++) @(posedge aclk);
        check(32'(n_commit), 32'h1);
        reg_rd(ba(REG_COMMIT_IDX));
        check(rdv, 32'h0);
        $display("test commit bit done");
        repeat (3) begin
            a1 = 16'($urandom_range(0, 16'hff00));
            a2 = 16'($urandom);
            c1 = $urandom_range(2, 6);
            lst = '{8'(c1 - 1), a1[15:8], a1[7:0], 8'h00, a2[15:8],
                a2[7:0], OP_END};
            nvm.scnt = 0;
            walk(CTRL_SAVE_BIT, 1);
            check(32'(nvm.scnt), 32'(c1 + 1));
            for (int k = 0; k < c1; k++)
                check(32'(nvm.smem[k]), 32'(cfg_init(a1 + 16'(k))));
            check(32'(nvm.smem[c1]), 32'(cfg_init(a2)));
        end
        $display("test save done");
        lst = '{8'h01, a1[15:8], a1[7:0], OP_COMMIT, OP_END};
        nvm.rmem[0] = 8'($urandom);
        nvm.rmem[1] = 8'($urandom);
        nvm.rptr = 0;
        nvm.rcnt = 2;
        n0 = n_commit;
        walk(CTRL_LOAD_BIT, 1);
        check(32'(nvm.cfg_mem[a1]), 32'(nvm.rmem[0]));
        check(32'(nvm.cfg_mem[a1 + 16'h1]), 32'(nvm.rmem[1]));
        check(32'(n_commit), 32'(n0 + 1));
        $display("test restore done");
        lst = '{OP_END, 8'h00, 8'h00, 8'h00};
        nvm.scnt = 0;
        walk(CTRL_SAVE_BIT, 0);
        check(32'(nvm.scnt), 32'h0);
        $display("test end of list done");
        finish_test();
    end
endmodule
